// file: core/phys_layer_control_reg.sv
// Purpose: physical layer control register of the serial frame interface
// Assumes: frame_valid pulses once per complete 16-bit frame, on clk
// Notes:   CAN off-line counter runs here; readback word is registered
`timescale 1ns/1ps
`include "phys_layer_control_map.svh"
module phys_layer_control_reg #(
    parameter int OFFL_SHORT_CYC = `PLR_OFFL_SHORT_MS * `PLR_CYCLES_PER_MS,
    parameter int OFFL_LONG_CYC  = `PLR_OFFL_LONG_MS * `PLR_CYCLES_PER_MS,
    parameter int OFFL_WAKE_CYC  = `PLR_OFFL_WAKE_MS * `PLR_CYCLES_PER_MS
) (
    input  wire logic                               clk,
    input  wire logic                               resetn,
    input  wire logic                               frame_valid,
    input  wire logic [15:0]                        frame_data,
    input  wire phys_layer_control_pkg::sys_mode_type sys_mode,
    input  wire logic [15:0]                        gp_readback_one,
    input  wire logic                               enter_online,
    input  wire logic                               can_wake_event,
    input  wire logic                               can_bus_activity,
    input  wire logic                               supply_short_pin,
    input  wire logic                               rx_clamp_pin,
    input  wire logic                               tx_clamp_pin,
    input  wire logic                               can_txd_in,
    input  wire logic                               lin_bus_wake_pin,
    output logic [15:0]                             readback_data,
    output logic                                    readback_valid,
    output logic                                    partial_network_sleep_allow,
    output logic                                    can_offline,
    output logic                                    can_tx_enable,
    output logic                                    can_rxd_loop,
    output logic                                    can_loop_active,
    output logic                                    supply_restart,
    output logic                                    lin_slope_slow,
    output logic                                    lin_term_high_voltage,
    output logic                                    lin_wake_request,
    output logic                                    lin_tx_enable
);
    import phys_layer_control_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage feeds only the second
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic       txd_s;
    logic       short_s;
    logic       rxc_s;
    logic       txc_s;
    logic       linw_s;
    logic       linw1_q;
    logic       linw2_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            linw1_q <= 1'b0;
            linw2_q <= 1'b0;
        end else begin
            sync1_q <= {can_txd_in, supply_short_pin, rx_clamp_pin, tx_clamp_pin};
            sync2_q <= sync1_q;
            linw1_q <= lin_bus_wake_pin;
            linw2_q <= linw1_q;
        end
    end
    assign txd_s   = sync2_q[3];
    assign short_s = sync2_q[2];
    assign rxc_s   = sync2_q[1];
    assign txc_s   = sync2_q[0];
    assign linw_s  = linw2_q;

    ////////////////////////////////////////////////////////////////////////
    // frame decode
    logic addr_hit;
    logic write_ok;
    logic do_write;
    // address match, shared by the decode and the checks so both read the same field
    function automatic logic reg_selected(input logic [15:0] frame);
        reg_selected = (frame[`PLR_ADDR_HI:`PLR_ADDR_LO] == `PLR_ADDR_THIS);
    endfunction
    assign addr_hit = frame_valid && reg_selected(frame_data);
    assign write_ok = (sys_mode == MODE_NORMAL) || (sys_mode == MODE_STANDBY);
    // a write needs a frame that is not read-only, in Normal or Standby mode
    assign do_write = addr_hit && !frame_data[`PLR_BIT_RO] && write_ok;

    ////////////////////////////////////////////////////////////////////////
    // configuration register and supply short memory
    logic [11:0] cfg_q, cfg_d;
    logic        short_seen_q, short_seen_d;
    logic        restart_q, restart_d;
    logic        fault;
    assign fault = short_s || rxc_s || txc_s;

    always_comb begin
        cfg_d        = cfg_q;
        short_seen_d = short_seen_q || short_s;
        restart_d    = 1'b0;
        if (do_write) begin
            cfg_d = frame_data[`PLR_FIELD_HI:0] & `PLR_WRITE_MASK;
            if (frame_data[`PLR_BIT_CAN_TXD] && short_seen_q && !short_s) begin
                restart_d    = 1'b1;
                short_seen_d = 1'b0;
            end
        end
        // hardware clear and set applied after the write so they win
        if (enter_online) cfg_d[`PLR_BIT_PN_SLEEP] = 1'b0;
        if (fault) cfg_d[`PLR_BIT_CAN_TXD] = 1'b1;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_q        <= `PLR_CFG_RESET;
            short_seen_q <= 1'b0;
            restart_q    <= 1'b0;
        end else begin
            cfg_q        <= cfg_d;
            short_seen_q <= short_seen_d;
            restart_q    <= restart_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readback returns the value before this frame's write
    logic [15:0] rb_q, rb_d;
    logic        rbv_q, rbv_d;
    always_comb begin
        rbv_d = addr_hit;
        rb_d  = rb_q;
        if (addr_hit) begin
            if (frame_data[`PLR_BIT_RB_SEL]) rb_d = gp_readback_one;
            else rb_d = {`PLR_ADDR_THIS, 2'h0, cfg_q};
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rb_q  <= `PLR_RB_RESET;
            rbv_q <= 1'b0;
        end else begin
            rb_q  <= rb_d;
            rbv_q <= rbv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // off-line timer: short or long reload on activity, wake reload after wake-up
    logic [31:0] offl_cnt_q, offl_cnt_d;
    logic        offl_q, offl_d;
    always_comb begin
        offl_cnt_d = offl_cnt_q;
        offl_d     = offl_q;
        if (can_wake_event) begin
            offl_cnt_d = 32'(OFFL_WAKE_CYC);
            offl_d     = 1'b0;
        end else if (can_bus_activity) begin
            offl_cnt_d = cfg_q[`PLR_BIT_OFFL_SEL] ? 32'(OFFL_LONG_CYC) : 32'(OFFL_SHORT_CYC);
            offl_d     = 1'b0;
        end else if (offl_cnt_q != 32'h0) begin
            offl_cnt_d = offl_cnt_q - 32'h1;
        end else begin
            offl_d = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            offl_cnt_q <= 32'h0;
            offl_q     <= 1'b0;
        end else begin
            offl_cnt_q <= offl_cnt_d;
            offl_q     <= offl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered physical layer controls
    logic [7:0] ctl_q, ctl_d;
    always_comb begin
        ctl_d[0] = cfg_d[`PLR_BIT_PN_SLEEP];
        ctl_d[1] = !cfg_d[`PLR_BIT_CAN_TXD];
        ctl_d[2] = cfg_d[`PLR_BIT_LOOPBACK] && cfg_d[`PLR_BIT_CAN_TXD];
        ctl_d[3] = ctl_d[2] ? txd_s : 1'b1;
        ctl_d[4] = cfg_d[`PLR_BIT_LIN_SLOPE];
        ctl_d[5] = cfg_d[`PLR_BIT_LIN_TERM];
        ctl_d[6] = cfg_q[`PLR_BIT_LIN_WAKE] && linw_s;
        ctl_d[7] = !cfg_d[`PLR_BIT_LIN_TXD];
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) ctl_q <= `PLR_CTL_RESET;
        else ctl_q <= ctl_d;
    end

    assign readback_data               = rb_q;
    assign readback_valid              = rbv_q;
    assign partial_network_sleep_allow = ctl_q[0];
    assign can_tx_enable               = ctl_q[1];
    assign can_loop_active             = ctl_q[2];
    assign can_rxd_loop                = ctl_q[3];
    assign lin_slope_slow              = ctl_q[4];
    assign lin_term_high_voltage       = ctl_q[5];
    assign lin_wake_request            = ctl_q[6];
    assign lin_tx_enable               = ctl_q[7];
    assign can_offline                 = offl_q;
    assign supply_restart              = restart_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_blocked_write;
        frame_valid && reg_selected(frame_data) && !frame_data[`PLR_BIT_RO] && !write_ok;
    endsequence
    sequence s_quiet_hw;
        !fault && !enter_online;
    endsequence
    sequence s_fault_seen;
        fault;
    endsequence
    // restart needs a remembered short that has since gone away
    sequence s_restart_write;
        do_write && frame_data[`PLR_BIT_CAN_TXD] && short_seen_q && !short_s;
    endsequence

    AST_NO_WRITE_OUTSIDE_MODE: assert property (@(posedge clk) disable iff (!resetn)
        (s_blocked_write and s_quiet_hw) |=> $stable(cfg_q))
        else $error("config changed outside normal or standby");
    AST_WRITE_TAKES_FIELDS: assert property (@(posedge clk) disable iff (!resetn)
        do_write && !fault && !enter_online |=> cfg_q == ($past(frame_data[`PLR_FIELD_HI:0]) & `PLR_WRITE_MASK))
        else $error("config write lost");
    AST_RO_NO_CHANGE: assert property (@(posedge clk) disable iff (!resetn)
        addr_hit && frame_data[`PLR_BIT_RO] && !fault && !enter_online |=> $stable(cfg_q))
        else $error("read only frame changed config");
    AST_READBACK_SELECT: assert property (@(posedge clk) disable iff (!resetn)
        addr_hit && frame_data[`PLR_BIT_RB_SEL] |=> readback_valid && readback_data == $past(gp_readback_one))
        else $error("wrong readback source");
    AST_OTHER_ADDR_IGNORED: assert property (@(posedge clk) disable iff (!resetn)
        frame_valid && !reg_selected(frame_data) |=> !readback_valid)
        else $error("foreign address answered");
    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        ~|(cfg_q & ~`PLR_WRITE_MASK))
        else $error("reserved config bit set");
    AST_ONLINE_CLEARS: assert property (@(posedge clk) disable iff (!resetn)
        enter_online |=> !cfg_q[`PLR_BIT_PN_SLEEP] && !partial_network_sleep_allow)
        else $error("sleep allow not cleared");
    AST_SLEEP_ALLOW_FOLLOWS: assert property (@(posedge clk) disable iff (!resetn)
        partial_network_sleep_allow == cfg_q[`PLR_BIT_PN_SLEEP])
        else $error("sleep allow output mismatch");
    AST_FAULT_DISABLES_TX: assert property (@(posedge clk) disable iff (!resetn)
        s_fault_seen |=> cfg_q[`PLR_BIT_CAN_TXD] && !can_tx_enable)
        else $error("fault did not disable transmitter");
    // controls other than the LIN wake request load on the same edge as the config, so they compare with cfg_q directly
    AST_TX_FOLLOWS_CFG: assert property (@(posedge clk) disable iff (!resetn)
        can_tx_enable == !cfg_q[`PLR_BIT_CAN_TXD])
        else $error("transmitter enable mismatch");
    AST_LOOPBACK_ONLY_OFF: assert property (@(posedge clk) disable iff (!resetn)
        can_loop_active |-> !can_tx_enable)
        else $error("loopback with transmitter on");
    AST_NO_LOOP_IDLE_RXD: assert property (@(posedge clk) disable iff (!resetn)
        !can_loop_active |-> can_rxd_loop)
        else $error("receive data forwarded without loopback");
    AST_LIN_TX: assert property (@(posedge clk) disable iff (!resetn)
        lin_tx_enable == !cfg_q[`PLR_BIT_LIN_TXD])
        else $error("lin transmitter enable mismatch");
    AST_LIN_SLOPE: assert property (@(posedge clk) disable iff (!resetn)
        lin_slope_slow == cfg_q[`PLR_BIT_LIN_SLOPE])
        else $error("lin slope mismatch");
    AST_LIN_TERM: assert property (@(posedge clk) disable iff (!resetn)
        lin_term_high_voltage == cfg_q[`PLR_BIT_LIN_TERM])
        else $error("lin termination supply mismatch");
    AST_LIN_WAKE_GATED: assert property (@(posedge clk) disable iff (!resetn)
        !$past(cfg_q[`PLR_BIT_LIN_WAKE]) |-> !lin_wake_request)
        else $error("lin wake while disabled");
    AST_RESTART_PULSE: assert property (@(posedge clk) disable iff (!resetn)
        s_restart_write |=> supply_restart ##1 !supply_restart)
        else $error("supply restart pulse wrong");
    AST_RESTART_NEEDS_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        supply_restart |-> $past(do_write))
        else $error("supply restart without write");
    // off-line timer: reload values and expiry
    AST_OFFLINE_WAKE: assert property (@(posedge clk) disable iff (!resetn)
        can_wake_event |=> !can_offline && offl_cnt_q == 32'(OFFL_WAKE_CYC))
        else $error("wake reload wrong");
    AST_OFFLINE_ACTIVITY: assert property (@(posedge clk) disable iff (!resetn)
        can_bus_activity && !can_wake_event |=> !can_offline &&
            offl_cnt_q == ($past(cfg_q[`PLR_BIT_OFFL_SEL]) ? 32'(OFFL_LONG_CYC) : 32'(OFFL_SHORT_CYC)))
        else $error("activity reload wrong");
    AST_OFFLINE_AT_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        offl_cnt_q == 32'h0 && !can_wake_event && !can_bus_activity |=> can_offline)
        else $error("off-line not entered at expiry");
endmodule

// file: inc/phys_layer_control_map.svh
// Purpose: offsets, field positions, reset values and timing of the physical layer control frame
// Assumes: 16-bit frame, address in the two top bits
// Notes:   included by bare name
`ifndef PHYS_LAYER_CONTROL_MAP_SVH
`define PHYS_LAYER_CONTROL_MAP_SVH
`define PLR_ADDR_HI        15
`define PLR_ADDR_LO        14
`define PLR_ADDR_THIS      2'h3
`define PLR_BIT_RB_SEL     13
`define PLR_BIT_RO         12
`define PLR_BIT_PN_SLEEP   10
`define PLR_BIT_OFFL_SEL   9
`define PLR_BIT_CAN_TXD    8
`define PLR_BIT_LOOPBACK   7
`define PLR_BIT_LIN_SLOPE  4
`define PLR_BIT_LIN_TERM   2
`define PLR_BIT_LIN_WAKE   1
`define PLR_BIT_LIN_TXD    0
`define PLR_WRITE_MASK     12'h797
`define PLR_CFG_RESET      12'h000
`define PLR_FIELD_HI       11
`define PLR_CTL_RESET      8'h8A
`define PLR_RB_RESET       16'h0000
`define PLR_OFFL_SHORT_MS  64
`define PLR_OFFL_LONG_MS   256
`define PLR_OFFL_WAKE_MS   400
`define PLR_CYCLES_PER_MS  250000
`endif

// file: inc/phys_layer_control_pkg.sv
// Purpose: types shared by the physical layer control register
// Assumes: system mode code supplied by the mode controller
// Notes:   mode encoding is local to this block
package phys_layer_control_pkg;
    typedef enum logic [2:0] {
        MODE_STARTUP  = 3'h0,
        MODE_RESTART  = 3'h1,
        MODE_NORMAL   = 3'h3,
        MODE_STANDBY  = 3'h2,
        MODE_SLEEP    = 3'h6,
        MODE_FLASH    = 3'h7,
        MODE_FAILSAFE = 3'h5
    } sys_mode_type;
endpackage

// file: testbench/host_frame_master.sv
// Purpose: host model issuing serial control frames
// Assumes: one-cycle frame pulse driven at the falling edge
// Notes:   reserved field bits are always cleared before sending
`timescale 1ns/1ps
`include "phys_layer_control_map.svh"
module host_frame_master (
    input  wire logic        clk,
    input  wire logic        readback_valid,
    input  wire logic [15:0] readback_data,
    output logic             frame_valid,
    output logic [15:0]      frame_data
);
    initial begin
        frame_valid = 1'b0;
        frame_data  = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one frame, then a bounded wait for the answer word
    task automatic send(input logic [1:0] addr, input logic sel, input logic ro,
                        input logic [11:0] fields, output logic [15:0] rb, output logic got);
        @(negedge clk);
        frame_valid = 1'b1;
        frame_data  = {addr, sel, ro, fields & `PLR_WRITE_MASK};
        got = 1'b0;
        rb  = 16'h0000;
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            frame_valid = 1'b0;
            frame_data  = ~frame_data; // released data must not look stale
            if (readback_valid === 1'b1 && !got) begin
                got = 1'b1;
                rb  = readback_data;
            end
        end
    endtask
endmodule

// file: testbench/phys_layer_control_reg_tb.sv
// Purpose: self-checking bench for the physical layer control register
// Assumes: short off-line counts 20/50/80 stand in for 64/256/400 ms
// Notes:   expectations kept in a shadow copy of the config field
`timescale 1ns/1ps
module phys_layer_control_reg_tb;
    import phys_layer_control_pkg::*;
    logic clk = 0, resetn = 0, frame_valid, enter_online = 0, wake = 0, act = 0, got;
    logic [2:0] pin = 0;
    logic txd = 1, lin_pin = 0, rb_valid, pn, offl, can_te, rxd, loop_a, restart, slow, term, lwake, lin_te;
    logic [15:0] frame_data, gp = 16'hA5C3, rb_data, rb;
    logic [11:0] cfg = 12'h000;
    sys_mode_type mode = MODE_NORMAL;
    int n_fail = 0, samples_checked = 0, n_restart = 0;
    always #2 clk = ~clk;
    // the restart pulse stands one cycle, so count the cycles it is high
    always @(negedge clk) if (restart === 1'b1) n_restart++;
    host_frame_master host (.clk(clk), .readback_valid(rb_valid), .readback_data(rb_data),
        .frame_valid(frame_valid), .frame_data(frame_data));
    phys_layer_control_reg #(.OFFL_SHORT_CYC(20), .OFFL_LONG_CYC(50), .OFFL_WAKE_CYC(80)) DUT (
        .clk(clk), .resetn(resetn), .frame_valid(frame_valid), .frame_data(frame_data), .sys_mode(mode),
        .gp_readback_one(gp), .enter_online(enter_online), .can_wake_event(wake), .can_bus_activity(act),
        .supply_short_pin(pin[0]), .rx_clamp_pin(pin[1]), .tx_clamp_pin(pin[2]), .can_txd_in(txd),
        .lin_bus_wake_pin(lin_pin), .readback_data(rb_data), .readback_valid(rb_valid),
        .partial_network_sleep_allow(pn), .can_offline(offl), .can_tx_enable(can_te), .can_rxd_loop(rxd),
        .can_loop_active(loop_a), .supply_restart(restart), .lin_slope_slow(slow),
        .lin_term_high_voltage(term), .lin_wake_request(lwake), .lin_tx_enable(lin_te));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // write frame; the answer shows the config before this write
    task automatic wr(input logic sel, input logic ro, input logic [11:0] f);
        host.send(2'h3, sel, ro, f, rb, got);
        check({15'h0, got}, 16'h0001);
        if (!sel) check(rb, {4'hC, cfg});
        if (!ro && (mode == MODE_NORMAL || mode == MODE_STANDBY)) cfg = f & 12'h797;
        cyc(3);
    endtask
    task automatic t_fields;
        check({11'h0, pn, can_te, lin_te, rxd, rb_valid}, 16'h000E);
        wr(0, 0, 12'h697);
        wr(0, 1, 12'hFFF);
        check({9'h0, term, slow, pn, can_te, lin_te, rxd, loop_a}, 16'h007A);
        host.send(2'h2, 0, 0, 12'h000, rb, got);
        check({15'h0, got}, 16'h0000);
        gp = 16'h5A3C;
        wr(1, 1, 12'h000);
        check(rb, 16'h5A3C);
    endtask
    // only Normal and Standby take writes; Standby last leaves a known config
    task automatic t_modes;
        sys_mode_type m[6] = '{MODE_STARTUP, MODE_RESTART, MODE_SLEEP, MODE_FLASH, MODE_FAILSAFE, MODE_STANDBY};
        foreach (m[i]) begin
            mode = m[i];
            wr(0, 0, 12'h001);
            wr(0, 1, 12'h000);
        end
        mode = MODE_NORMAL;
        wr(0, 0, 12'h400);
        check({15'h0, pn}, 16'h0001);
        enter_online = 1;
        cyc(1);
        enter_online = 0;
        cyc(3);
        check({15'h0, pn}, 16'h0000);
        cfg[10] = 1'b0;
    endtask
    task automatic t_can;
        wr(0, 0, 12'h180);
        txd = 0;
        cyc(4);
        check({13'h0, can_te, rxd, loop_a}, 16'h0001);
        wr(0, 0, 12'h100);
        check({15'h0, rxd}, 16'h0001);
        for (int p = 0; p < 3; p++) begin
            wr(0, 0, 12'h000);
            pin[p] = 1;
            cyc(5);
            pin[p] = 0;
            cyc(4);
            check({15'h0, can_te}, 16'h0000);
            cfg[8] = 1'b1;
            if (p == 0) begin
                check({15'h0, restart}, 16'h0000);
                host.send(2'h3, 0, 0, 12'h100, rb, got);
                check(16'(n_restart), 16'h0001);
                cyc(3);
            end
        end
    endtask
    // off-line after bus activity (short, long) and after a wake-up
    task automatic t_timer;
        wr(0, 0, 12'h002);
        lin_pin = 1;
        cyc(5);
        check({15'h0, lwake}, 16'h0001);
        lin_pin = 0;
        for (int k = 0; k < 3; k++) begin
            if (k == 1) wr(0, 0, 12'h200);
            if (k < 2) act = 1;
            else wake = 1;
            cyc(1);
            {act, wake} = 2'b00;
            cyc(k == 0 ? 20 : k == 1 ? 50 : 80);
            check({15'h0, offl}, 16'h0000);
            cyc(1);
            check({15'h0, offl}, 16'h0001);
        end
        lin_pin = 1;
        cyc(5);
        check({15'h0, lwake}, 16'h0000);
        lin_pin = 0;
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(2);
        resetn = 1;
        t_fields();
        t_modes();
        t_can();
        t_timer();
        complete_run();
    end
    // watchdog: the tests need about 380 cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule
